// file: rtl/spi_flash_pkg.sv
// Shared constants, types and decode helpers for the serial flash front end.
package spi_flash_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam logic [7:0] OP_MASK = 8'hF7;
	localparam logic [7:0] OPC_SET_WL = 8'h06;
	localparam logic [7:0] OPC_CLR_WL = 8'h04;
	localparam logic [7:0] OPC_RD_STAT = 8'h05;
	localparam logic [7:0] OPC_WR_STAT = 8'h01;
	localparam logic [7:0] OPC_RD_ARR = 8'h03;
	localparam logic [7:0] OPC_PROG = 8'h02;
	localparam logic [7:0] OPC_SECT_ERASE = 8'h52;
	localparam logic [7:0] OPC_CHIP_ERASE = 8'h62;
	localparam logic [7:0] OPC_RD_IDENT = 8'h15;
	// Status register field positions.
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LO = 2;
	localparam int ST_BP_HI = 3;
	localparam int ST_PIN_PROTECT_ENABLE = 7;
	localparam logic [7:0] STATUS_BUSY_VAL = 8'hFF;
	// Power-up values of latch and protection bits.
	localparam logic WEL_RST = 1'b0;
	localparam logic [1:0] BP_RST = 2'b00;
	localparam logic PIN_PROTECT_ENABLE_RST = 1'b0;
	// Array addressing: 18 address bits, sector in the top two.
	localparam int ADDR_BITS = 18;
	localparam logic [1:0] ADDR_LAST_BYTE = 2'd2;
	localparam logic [1:0] BP_ALL = 2'b11;
	// Internal cycle times and their clock counts.
	localparam int SR_WRITE_MS = 60;
	localparam int SR_WRITE_CYC = SR_WRITE_MS * (CLK_HZ / 1000);
	localparam int PROG_US = 50;
	localparam int PROG_CYC = PROG_US * (CLK_HZ / 1_000_000);
	localparam int SECT_ERASE_S = 1;
	localparam int SECT_ERASE_CYC = SECT_ERASE_S * CLK_HZ;
	localparam int CHIP_ERASE_S = 4;
	localparam int CHIP_ERASE_CYC = CHIP_ERASE_S * CLK_HZ;
	// Identification bytes; both values are arbitrary.
	localparam logic [7:0] MAKER_ID = 8'hA5;
	localparam logic [7:0] DEVICE_ID = 8'h3C;
	// Link pin reset levels {cs_n, sck, si, hold_n, wp_n}.
	localparam logic [4:0] LINK_RST = 5'h13;
	// Host register map and control fields.
	localparam logic [7:0] REG_DATA = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CTRL_SEL = 0;
	localparam int CTRL_HOLD_N = 1;
	localparam int CTRL_WP_N = 2;
	localparam int CTRL_CPOL = 3;
	localparam logic [3:0] CTRL_RST = 4'h6;
	localparam int HALF_DIV = 8;

	typedef enum logic [3:0] {
		CMD_SET_WL, CMD_CLR_WL, CMD_RD_STAT, CMD_WR_STAT, CMD_RD_ARR,
		CMD_PROG, CMD_SECT_ERASE, CMD_CHIP_ERASE, CMD_RD_IDENT, CMD_BAD
	} cmd_t;

	// Maps an op-code to a command, bit 3 being ignored.
	function automatic cmd_t decode(input logic [7:0] op);
		logic [7:0] m;
		m = op & OP_MASK;
		if (m == OPC_SET_WL) return CMD_SET_WL;
		else if (m == OPC_CLR_WL) return CMD_CLR_WL;
		else if (m == OPC_RD_STAT) return CMD_RD_STAT;
		else if (m == OPC_WR_STAT) return CMD_WR_STAT;
		else if (m == OPC_RD_ARR) return CMD_RD_ARR;
		else if (m == OPC_PROG) return CMD_PROG;
		else if (m == OPC_SECT_ERASE) return CMD_SECT_ERASE;
		else if (m == OPC_CHIP_ERASE) return CMD_CHIP_ERASE;
		else if (m == OPC_RD_IDENT) return CMD_RD_IDENT;
		else return CMD_BAD;
	endfunction
endpackage

// file: rtl/spi_link_if.sv
// Serial link between the flash front end and its master.
interface spi_link_if;
	logic cs_n;
	logic sck;
	logic si;
	logic so;
	logic so_oe_n;
	logic hold_n;
	logic wp_n;
	logic so_line;

	// The output wire floats high when the device does not drive it.
	assign so_line = so_oe_n ? 1'b1 : so;

	modport dev (input cs_n, input sck, input si, input hold_n,
		input wp_n, output so, output so_oe_n);
	modport host (output cs_n, output sck, output si, output hold_n,
		output wp_n, input so_line);
endinterface

// file: rtl/in_sync3.sv
// Three-stage input synchroniser whose level moves when stages 2 and 3 agree.
module in_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} sync_s_t;

	sync_s_t q;
	sync_s_t d;

	// Per bit, the filtered level follows only once stages 2 and 3 match.
	always_comb
	begin
		d = q;
		d.s1 = din;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++)
		begin
			if (q.s2[i] == q.s3[i])
			begin
				d.lvl[i] = q.s3[i];
			end
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end
		else if (ce)
		begin
			q <= d;
		end
	end

	assign dout = q.lvl;
endmodule

// file: rtl/flash_front_end.sv
// Device end: serial command decoder, status register and write lockout.
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
module flash_front_end #(
	parameter int SR_CYC = spi_flash_pkg::SR_WRITE_CYC,
	parameter int PROG_CYC = spi_flash_pkg::PROG_CYC,
	parameter int SECT_CYC = spi_flash_pkg::SECT_ERASE_CYC,
	parameter int CHIP_CYC = spi_flash_pkg::CHIP_ERASE_CYC,
	parameter logic [7:0] MAKER = spi_flash_pkg::MAKER_ID,
	parameter logic [7:0] DEVICE = spi_flash_pkg::DEVICE_ID
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	// Serial link
	spi_link_if.dev link,
	// Array back end
	output logic arr_start,
	output spi_flash_pkg::cmd_t arr_cmd,
	output logic [spi_flash_pkg::ADDR_BITS-1:0] arr_addr,
	output logic [7:0] arr_wdata,
	input wire logic [7:0] arr_rdata,
	// Status view
	output logic [7:0] status
);
	typedef enum logic [2:0] {
		ST_OP, ST_ADDR, ST_WDATA, ST_OUT, ST_IGNORE
	} dev_state_t;

	typedef struct packed {
		dev_state_t st;
		spi_flash_pkg::cmd_t cmd;
		logic [7:0] sh;
		logic [7:0] out;
		logic [2:0] bits;
		logic [1:0] nbytes;
		logic [spi_flash_pkg::ADDR_BITS-1:0] addr;
		logic [7:0] wdata;
		logic got_data;
		logic wel;
		logic [1:0] bp;
		logic pin_protect_enable;
		logic [7:0] new_stat;
		logic upd_stat;
		logic abort;
		logic busy;
		logic [31:0] tmr;
		logic cs_n_p;
		logic sck_p;
		logic wp_n_p;
		logic so;
		logic start;
	} dev_s_t;

	dev_s_t q;
	dev_s_t d;
	logic [4:0] pins;
	logic cs_n, sck, si, hold_n, wp_n;
	logic sel, rise, fall;
	logic [7:0] byte_in;
	logic [7:0] stat_now;
	logic [7:0] next_out;
	logic hw_locked;
	logic [31:0] op_time;

	// All link inputs come from another clock domain.
	in_sync3 #(
		.W(5),
		.RST_VAL(spi_flash_pkg::LINK_RST)
	) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.din({link.cs_n, link.sck, link.si, link.hold_n, link.wp_n}),
		.dout(pins)
	);

	assign {cs_n, sck, si, hold_n, wp_n} = pins;

	// Clock edges count only while selected and not paused.
	assign sel = !cs_n && hold_n;
	assign rise = sel && sck && !q.sck_p;
	assign fall = sel && !sck && q.sck_p;
	assign byte_in = {q.sh[6:0], si};
	assign hw_locked = q.pin_protect_enable && !wp_n;

	// Live status byte.
	always_comb
	begin
		stat_now = '0;
		stat_now[spi_flash_pkg::ST_BUSY] = q.busy;
		stat_now[spi_flash_pkg::ST_WEL] = q.wel;
		stat_now[spi_flash_pkg::ST_BP_LO] = q.bp[0];
		stat_now[spi_flash_pkg::ST_BP_HI] = q.bp[1];
		stat_now[spi_flash_pkg::ST_PIN_PROTECT_ENABLE] = q.pin_protect_enable;
		if (q.busy)
		begin
			stat_now = spi_flash_pkg::STATUS_BUSY_VAL;
		end
	end

	// Next byte to shift out, chosen by the active read command.
	always_comb
	begin
		next_out = '0;
		case (q.cmd)
			spi_flash_pkg::CMD_RD_STAT: next_out = stat_now;
			spi_flash_pkg::CMD_RD_IDENT:
			begin
				if (q.nbytes == 2'd0)
				begin
					next_out = MAKER;
				end
				else if (q.nbytes == 2'd1)
				begin
					next_out = DEVICE;
				end
			end
			spi_flash_pkg::CMD_RD_ARR: next_out = arr_rdata;
			default: next_out = '0;
		endcase
	end

	// Whether the captured address falls in a locked-out sector.
	function automatic logic locked(
		input logic [1:0] bp,
		input logic [spi_flash_pkg::ADDR_BITS-1:0] a
	);
		logic [1:0] sec;
		sec = a[spi_flash_pkg::ADDR_BITS-1 -: 2];
		case (bp)
			2'b01: return sec == 2'b11;
			2'b10: return sec[1];
			2'b11: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Cycle length for the pending array operation.
	always_comb
	begin
		op_time = 32'(PROG_CYC);
		if (q.cmd == spi_flash_pkg::CMD_SECT_ERASE)
		begin
			op_time = 32'(SECT_CYC);
		end
		else if (q.cmd == spi_flash_pkg::CMD_CHIP_ERASE)
		begin
			op_time = 32'(CHIP_CYC);
		end
	end

	// Command sequencing, internal write timer and lockout checks.
	always_comb
	begin
		d = q;
		d.start = 1'b0;
		d.cs_n_p = cs_n;
		d.sck_p = sck;
		d.wp_n_p = wp_n;
		if (q.busy)
		begin
			if (q.tmr == '0)
			begin
				d.busy = 1'b0;
				d.wel = 1'b0;
				if (q.upd_stat)
				begin
					d.pin_protect_enable = q.new_stat[spi_flash_pkg::ST_PIN_PROTECT_ENABLE];
					d.bp[0] = q.new_stat[spi_flash_pkg::ST_BP_LO];
					d.bp[1] = q.new_stat[spi_flash_pkg::ST_BP_HI];
				end
			end
			else
			begin
				d.tmr = q.tmr - 32'd1;
			end
		end
		if (!cs_n && q.wp_n_p && !wp_n && q.pin_protect_enable
			&& q.cmd == spi_flash_pkg::CMD_WR_STAT)
		begin
			d.abort = 1'b1;
		end
		if (!cs_n && q.cs_n_p)
		begin
			// Selection restarts the sequence.
			d.st = ST_OP;
			d.cmd = spi_flash_pkg::CMD_BAD;
			d.bits = '0;
			d.nbytes = '0;
			d.got_data = 1'b0;
			d.abort = 1'b0;
		end
		else if (cs_n && !q.cs_n_p)
		begin
			// Deselection launches any accepted write.
			d.st = ST_OP;
			if (!q.busy && q.got_data && q.wel)
			begin
				if (q.cmd == spi_flash_pkg::CMD_WR_STAT)
				begin
					if (!q.abort && !hw_locked)
					begin
						d.busy = 1'b1;
						d.tmr = 32'(SR_CYC);
						d.upd_stat = 1'b1;
						d.new_stat = q.wdata;
					end
				end
				else if (!locked(q.bp, q.addr)
					|| (q.cmd == spi_flash_pkg::CMD_CHIP_ERASE
					&& q.bp != spi_flash_pkg::BP_ALL))
				begin
					d.busy = 1'b1;
					d.tmr = op_time;
					d.upd_stat = 1'b0;
					d.start = 1'b1;
				end
			end
		end
		else if (rise)
		begin
			d.sh = byte_in;
			d.bits = q.bits + 3'd1;
			if (q.bits == 3'd7)
			begin
				case (q.st)
					ST_OP:
					begin
						d.cmd = spi_flash_pkg::decode(byte_in);
						d.st = ST_IGNORE;
						if (q.busy && d.cmd != spi_flash_pkg::CMD_RD_STAT)
						begin
							d.cmd = spi_flash_pkg::CMD_BAD;
						end
						case (d.cmd)
							spi_flash_pkg::CMD_SET_WL: d.wel = 1'b1;
							spi_flash_pkg::CMD_CLR_WL: d.wel = 1'b0;
							spi_flash_pkg::CMD_RD_STAT: d.st = ST_OUT;
							spi_flash_pkg::CMD_RD_IDENT: d.st = ST_OUT;
							spi_flash_pkg::CMD_WR_STAT: d.st = ST_WDATA;
							spi_flash_pkg::CMD_RD_ARR: d.st = ST_ADDR;
							spi_flash_pkg::CMD_PROG: d.st = ST_ADDR;
							spi_flash_pkg::CMD_SECT_ERASE: d.st = ST_ADDR;
							spi_flash_pkg::CMD_CHIP_ERASE: d.got_data = 1'b1;
							default: d.st = ST_IGNORE;
						endcase
					end
					ST_ADDR:
					begin
						d.addr = {q.addr[spi_flash_pkg::ADDR_BITS-9:0], byte_in};
						d.nbytes = q.nbytes + 2'd1;
						if (q.nbytes == spi_flash_pkg::ADDR_LAST_BYTE)
						begin
							d.nbytes = '0;
							if (q.cmd == spi_flash_pkg::CMD_RD_ARR)
							begin
								d.st = ST_OUT;
							end
							else if (q.cmd == spi_flash_pkg::CMD_PROG)
							begin
								d.st = ST_WDATA;
							end
							else
							begin
								d.st = ST_IGNORE;
								d.got_data = 1'b1;
							end
						end
					end
					ST_WDATA:
					begin
						d.wdata = byte_in;
						d.got_data = 1'b1;
						d.st = ST_IGNORE;
					end
					default: d.st = q.st;
				endcase
			end
		end
		else if (fall && q.st == ST_OUT)
		begin
			// Output moves after the falling edge, top bit first.
			if (q.bits == 3'd0)
			begin
				d.so = next_out[7];
				d.out = {next_out[6:0], 1'b0};
				d.nbytes = q.nbytes + 2'd1;
				if (q.cmd == spi_flash_pkg::CMD_RD_IDENT && q.nbytes == 2'd2)
				begin
					d.nbytes = q.nbytes;
				end
				if (q.cmd == spi_flash_pkg::CMD_RD_ARR)
				begin
					d.addr = q.addr + 1'b1;
				end
			end
			else
			begin
				d.so = q.out[7];
				d.out = {q.out[6:0], 1'b0};
			end
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			q <= '0;
			q.st <= ST_OP;
			q.cmd <= spi_flash_pkg::CMD_BAD;
			q.wel <= spi_flash_pkg::WEL_RST;
			q.bp <= spi_flash_pkg::BP_RST;
			q.pin_protect_enable <= spi_flash_pkg::PIN_PROTECT_ENABLE_RST;
			q.cs_n_p <= 1'b1;
			q.wp_n_p <= 1'b1;
		end
		else if (ce)
		begin
			q <= d;
		end
	end

	// Output drives only while selected, unpaused and shifting a reply.
	assign link.so_oe_n = !(sel && q.st == ST_OUT);
	assign link.so = q.so;
	assign arr_start = q.start;
	assign arr_cmd = q.cmd;
	assign arr_addr = q.addr;
	assign arr_wdata = q.wdata;
	assign status = stat_now;
endmodule

// file: rtl/spi_host_ctrl.sv
// Host end: Wishbone-controlled byte master that drives the serial link.
module spi_host_ctrl #(
	parameter int HALF = spi_flash_pkg::HALF_DIV
) (
	// Clock and control
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ce,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Serial link
	spi_link_if.host link
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [3:0] ctrl;
		logic [7:0] tx;
		logic [7:0] rx;
		logic busy;
		logic sck;
		logic [15:0] div;
		logic [2:0] cnt;
		logic rose;
		logic mosi;
		logic hold_n;
	} host_s_t;

	host_s_t q;
	host_s_t d;
	logic miso;
	logic req;
	logic tick;

	// Returned data crosses in from the device domain.
	in_sync3 #(
		.W(1),
		.RST_VAL(1'b1)
	) u_sync (
		.core_clk(core_clk),
		.srst(srst),
		.ce(ce),
		.din(link.so_line),
		.dout(miso)
	);

	assign req = wb_cyc_i && wb_stb_i && !q.ack;
	assign tick = q.div == 16'(HALF - 1);

	// Register access, clock divider and byte shifter.
	always_comb
	begin
		d = q;
		d.ack = req;
		if (req && !wb_we_i)
		begin
			if (wb_adr_i == spi_flash_pkg::REG_DATA)
			begin
				d.rdat = {24'h000000, q.rx};
			end
			else if (wb_adr_i == spi_flash_pkg::REG_CTRL)
			begin
				d.rdat = {28'h0000000, q.ctrl};
			end
			else if (wb_adr_i == spi_flash_pkg::REG_STAT)
			begin
				d.rdat = {31'h00000000, q.busy};
			end
			else
			begin
				d.rdat = '0;
			end
		end
		if (req && wb_we_i && wb_sel_i[0])
		begin
			if (wb_adr_i == spi_flash_pkg::REG_CTRL)
			begin
				d.ctrl = wb_dat_i[3:0];
			end
			else if (wb_adr_i == spi_flash_pkg::REG_DATA && !q.busy)
			begin
				d.tx = {wb_dat_i[6:0], 1'b0};
				d.mosi = wb_dat_i[7];
				d.busy = 1'b1;
				d.cnt = '0;
				d.rose = 1'b0;
				d.div = '0;
			end
		end
		if (!q.busy)
		begin
			d.sck = q.ctrl[spi_flash_pkg::CTRL_CPOL];
		end
		else if (tick)
		begin
			d.div = '0;
			if (!q.sck)
			begin
				d.sck = 1'b1;
				d.rose = 1'b1;
			end
			else if (!q.rose)
			begin
				d.sck = 1'b0;
			end
			else
			begin
				d.rx = {q.rx[6:0], miso};
				d.cnt = q.cnt + 3'd1;
				d.rose = 1'b0;
				if (q.cnt == 3'd7)
				begin
					d.busy = 1'b0;
					d.sck = q.ctrl[spi_flash_pkg::CTRL_CPOL];
				end
				else
				begin
					d.sck = 1'b0;
					d.mosi = q.tx[7];
					d.tx = {q.tx[6:0], 1'b0};
				end
			end
		end
		else
		begin
			d.div = q.div + 16'd1;
		end
		if (!q.sck)
		begin
			d.hold_n = q.ctrl[spi_flash_pkg::CTRL_HOLD_N];
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			q <= '0;
			q.ctrl <= spi_flash_pkg::CTRL_RST;
			q.hold_n <= 1'b1;
		end
		else if (ce)
		begin
			q <= d;
		end
	end

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdat;
	assign link.cs_n = !q.ctrl[spi_flash_pkg::CTRL_SEL];
	assign link.sck = q.sck;
	assign link.si = q.mosi;
	assign link.hold_n = q.hold_n;
	assign link.wp_n = q.ctrl[spi_flash_pkg::CTRL_WP_N];
endmodule

// file: bench/spi_link_props.sv
// Assertion checker watching the serial link between the two ends.
module spi_link_props #(
	parameter int HALF = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Link signals
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe_n,
	input wire logic hold_n,
	input wire logic wp_n
);
	logic sck_q;
	logic [3:0] fall_q;

	// Counts cycles since the last falling serial clock edge, saturating.
	always_ff @(posedge core_clk)
	begin
		sck_q <= sck;
		if (srst)
			fall_q <= 4'hF;
		else if (sck_q && !sck)
			fall_q <= 4'h0;
		else if (fall_q != 4'hF)
			fall_q <= fall_q + 4'h1;
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);

	// Output stays off while deselected or paused.
	property p_desel_hiz;
		cs_n [*8] |-> so_oe_n;
	endproperty
	a_desel_hiz: assert property (p_desel_hiz)
		else $error("Output driven while deselected.");
	property p_hold_hiz;
		!hold_n [*8] |-> so_oe_n;
	endproperty
	a_hold_hiz: assert property (p_hold_hiz)
		else $error("Output driven while paused.");
	// The output turns on only for a selected, running device.
	property p_oe_on_sel;
		$fell(so_oe_n) |-> !cs_n && hold_n && !$past(cs_n, 3)
			&& $past(hold_n, 3);
	endproperty
	a_oe_on_sel: assert property (p_oe_on_sel)
		else $error("Output enabled without select.");
	// Reply bits move only shortly after a falling clock edge.
	property p_so_after_fall;
		!so_oe_n && !$past(so_oe_n) && $changed(so) |-> fall_q <= 4'h6;
	endproperty
	a_so_after_fall: assert property (p_so_after_fall)
		else $error("Reply bit moved away from a falling edge.");
	// Master data holds still through the high phase.
	property p_si_stable_high;
		$rose(sck) |=> $stable(si) [*7];
	endproperty
	a_si_stable_high: assert property (p_si_stable_high)
		else $error("Master data moved while clock high.");
	property p_hold_sck_low;
		$changed(hold_n) |-> !sck && !$past(sck);
	endproperty
	a_hold_sck_low: assert property (p_hold_sck_low)
		else $error("Pause changed while clock high.");
	property p_cs_sck_idle;
		$changed(cs_n) |-> $stable(sck) ##1 $stable(sck);
	endproperty
	a_cs_sck_idle: assert property (p_cs_sck_idle)
		else $error("Select moved while clock moving.");
	property p_sck_high_len;
		$fell(sck) |-> $past(sck, HALF);
	endproperty
	a_sck_high_len: assert property (p_sck_high_len)
		else $error("Clock high phase too short.");

	// Main scenarios reached.
	c_reply: cover property (!so_oe_n [*8]);
	c_pause: cover property ($fell(hold_n) && !cs_n);
	c_wp_fall: cover property ($fell(wp_n) && !cs_n);
endmodule

// file: bench/test_spi_flash_command_front_end.sv
// Testbench joining the host controller and the flash front end.
module test_spi_flash_command_front_end;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [23:0] TBL [5] = '{24'h020300, 24'h020201,
		24'h520101, 24'h5A0300, 24'h620001};
	logic core_clk;
	logic srst;
	logic cyc;
	logic stb;
	logic we;
	logic [7:0] adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic ack;
	logic arr_start;
	logic ce;
	logic [3:0] wb_sel;
	logic [7:0] arr_rdata;
	logic [7:0] status;
	logic [7:0] ctrl;
	logic [7:0] rx;
	int failures;
	int checked;
	int cycles;
	int starts;

	spi_link_if link();
	flash_front_end #(.SR_CYC(1000), .PROG_CYC(20), .SECT_CYC(30),
		.CHIP_CYC(40)) u_flash_front_end (.core_clk(core_clk),
		.srst(srst), .ce(ce), .link(link), .arr_start(arr_start),
		.arr_cmd(), .arr_addr(), .arr_wdata(), .arr_rdata(arr_rdata),
		.status(status));
	spi_host_ctrl #(.HALF(8)) u_spi_host_ctrl (.core_clk(core_clk),
		.srst(srst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(wb_sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
	spi_link_props u_spi_link_props (.core_clk(core_clk),
		.srst(srst), .cs_n(link.cs_n), .sck(link.sck), .si(link.si),
		.so(link.so), .so_oe_n(link.so_oe_n), .hold_n(link.hold_n),
		.wp_n(link.wp_n));

	// Free-running core clock.
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Counts cycles and launched array cycles; cuts a hang short.
	always @(posedge core_clk)
	begin
		cycles <= cycles + 1;
		if (arr_start === 1'b1)
			starts <= starts + 1;
		if (cycles == 60000)
		begin
			failures = failures + 1;
			finish_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked = checked + 1;
		if (seen !== exp)
		begin
			failures = failures + 1;
			$display("CHECK FAILED at %0t: saw %h, expected %h",
				$time, seen, exp);
		end
	endtask

	// One classic Wishbone cycle; read data lands in rx.
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		@(posedge core_clk);
		while (ack !== 1'b1 && n < 100)
		begin
			@(posedge core_clk);
			n = n + 1;
		end
		if (n == 100)
			failures = failures + 1;
		rx = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
	endtask

	// Sends one byte, waits for the shift to end, reads the reply.
	task automatic xfer(input logic [7:0] d);
		int n;
		n = 0;
		wb(1'b1, spi_flash_pkg::REG_DATA, d);
		rx = 8'h01;
		while (rx[0] !== 1'b0 && n < 1000)
		begin
			wb(1'b0, spi_flash_pkg::REG_STAT, 8'h00);
			n = n + 1;
		end
		wb(1'b0, spi_flash_pkg::REG_DATA, 8'h00);
	endtask

	// Control writes are followed by a settling gap for the link.
	task automatic set_ctrl(input logic [7:0] c);
		ctrl = c;
		wb(1'b1, spi_flash_pkg::REG_CTRL, c);
		repeat (10) @(posedge core_clk);
	endtask

	task automatic sel(input logic on);
		set_ctrl({ctrl[7:1], on});
	endtask

	task automatic cmd1(input logic [7:0] op);
		sel(1'b1);
		xfer(op);
		sel(1'b0);
	endtask

	task automatic rdstat(input logic [7:0] op);
		sel(1'b1);
		xfer(op);
		xfer(8'h00);
		sel(1'b0);
	endtask

	// Accepted status write, ignored latch set, busy view, then poll.
	task automatic wrstat(input logic [7:0] v);
		int n;
		n = 0;
		cmd1(8'h06);
		sel(1'b1);
		xfer(8'h01);
		xfer(v);
		sel(1'b0);
		cmd1(8'h06);
		sel(1'b1);
		xfer(8'h05);
		xfer(8'h00);
		check(rx, 8'hFF);
		while (rx === 8'hFF && n < 20)
		begin
			xfer(8'h00);
			n = n + 1;
		end
		sel(1'b0);
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Main sequence of tests.
	initial
	begin
		int n;
		{cyc, stb, we, adr, wdat} = '0;
		{failures, checked, cycles, starts} = '0;
		ctrl = 8'h06;
		ce = 1'b1;
		wb_sel = 4'hF;
		arr_rdata = 8'h5A;
		srst = 1'b1;
		repeat (12) @(posedge core_clk);
		srst <= 1'b0;
		repeat (4) @(posedge core_clk);
		wb(1'b0, spi_flash_pkg::REG_CTRL, 8'h00);
		check(rx, 8'h06);
		wb(1'b0, 8'h0C, 8'h00);
		check(rx, 8'h00);
		check(status, 8'h00);
		// A write with lane 0 disabled must leave the control word alone.
		wb_sel <= 4'h0;
		wb(1'b1, spi_flash_pkg::REG_CTRL, 8'h00);
		wb_sel <= 4'hF;
		wb(1'b0, spi_flash_pkg::REG_CTRL, 8'h00);
		check(rx, 8'h06);
		rdstat(8'h05);
		check(rx, 8'h00);
		$display("Test power-up done");
		cmd1(8'h0E);
		rdstat(8'h0D);
		check(rx, 8'h02);
		set_ctrl(ctrl & 8'hFB);
		cmd1(8'h0C);
		set_ctrl(ctrl | 8'h04);
		rdstat(8'h05);
		check(rx, 8'h00);
		sel(1'b1);
		xfer(8'h1D);
		xfer(8'h00);
		check(rx, spi_flash_pkg::MAKER_ID);
		xfer(8'h00);
		check(rx, spi_flash_pkg::DEVICE_ID);
		sel(1'b0);
		sel(1'b1);
		xfer(8'h0B);
		repeat (3) xfer(8'h00);
		xfer(8'h00);
		check(rx, 8'h5A);
		sel(1'b0);
		$display("Test decode done");
		sel(1'b1);
		xfer(8'h07);
		xfer(8'h05);
		check(rx, 8'hFF);
		xfer(8'h00);
		check(rx, 8'hFF);
		sel(1'b0);
		xfer(8'h05);
		check(rx, 8'hFF);
		rdstat(8'h05);
		check(rx, 8'h00);
		$display("Test refusal done");
		sel(1'b1);
		xfer(8'h01);
		xfer(8'h8C);
		sel(1'b0);
		rdstat(8'h05);
		check(rx, 8'h00);
		wrstat(8'h8C);
		check(rx, 8'h8C);
		check(status, 8'h8C);
		set_ctrl(ctrl & 8'hFB);
		cmd1(8'h06);
		cmd1(8'h01);
		rdstat(8'h05);
		check(rx & 8'hFD, 8'h8C);
		set_ctrl(ctrl | 8'h04);
		cmd1(8'h06);
		sel(1'b1);
		xfer(8'h01);
		xfer(8'h00);
		set_ctrl(ctrl & 8'hFB);
		sel(1'b0);
		set_ctrl(ctrl | 8'h04);
		rdstat(8'h05);
		check(rx & 8'hFD, 8'h8C);
		wrstat(8'h00);
		check(rx, 8'h00);
		set_ctrl(ctrl & 8'hFB);
		wrstat(8'h04);
		check(rx, 8'h04);
		$display("Test protection done");
		for (int i = 0; i < 5; i++)
		begin
			n = starts;
			cmd1(8'h06);
			sel(1'b1);
			xfer(TBL[i][23:16]);
			if (TBL[i][23:16] != 8'h62)
			begin
				xfer(TBL[i][15:8]);
				xfer(8'h00);
				xfer(8'h00);
			end
			if (TBL[i][23:16] == 8'h02)
				xfer(8'h77);
			sel(1'b0);
			rdstat(8'h05);
			check(8'(starts - n), TBL[i][7:0]);
			check(rx, (TBL[i][0] ? 8'h04 : 8'h06));
		end
		$display("Test lockout done");
		sel(1'b1);
		xfer(8'h05);
		set_ctrl(ctrl & 8'hFD);
		xfer(8'h00);
		check(rx, 8'hFF);
		set_ctrl(ctrl | 8'h02);
		xfer(8'h00);
		check(rx, 8'h04);
		sel(1'b0);
		set_ctrl(ctrl | 8'h08);
		sel(1'b1);
		xfer(8'h15);
		xfer(8'h00);
		check(rx, spi_flash_pkg::MAKER_ID);
		sel(1'b0);
		set_ctrl(ctrl & 8'hF7);
		$display("Test pause and mode done");
		finish_test();
	end
endmodule
